// ===== src/btp_dev_end.sv
// btp_dev_end: module end of the paged block-transfer link
// assumes: controller end on the same hclk joined through btp_link_if;
// the payload store sits outside and answers usr_rd_data in the same cycle
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - every exchange moves at most 64 words
// - halt communications while controller stops running
// - report page 255 in word 1 before configuration
// - keep exchanging until configuration page arrives
// - data pages first, then command pages
// - run command list or request it
// - module chooses next write page via word 1
// - write word 0 selects page kind
// - words 1 to 63 interpreted by kind
// - controller always writes full 64 words
// - controller files read payload by page
// - controller copies word 1 into word 0
// - controller may adjust requested write page
// - controller fills buffer, clears request bits
// - controller signals write done by strobe
// - controller sends configuration after power-up
// - page 255 adopts configuration at any time
module btp_dev_end
  import btp_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link to the controller
  btp_link_if.dev link,
  // read page payload source
  output logic [7:0] usr_rd_page,
  output logic [5:0] usr_rd_word,
  input wire logic [15:0] usr_rd_data,
  // write page payload sink
  output logic usr_wr_valid,
  output btp_kind_t usr_wr_kind,
  output logic [7:0] usr_wr_page,
  output logic [5:0] usr_wr_word,
  output logic [15:0] usr_wr_data,
  // status
  output logic cfg_ok,
  output logic cfg_pulse,
  output logic comm_active,
  output logic cmd_exec
);

  typedef enum logic [2:0] {S_IDLE, S_READ, S_RECV, S_FULL, S_DRAIN} btp_dev_st_t;

  btp_dev_st_t st_r, st_nxt;
  btp_kind_t kind;
  logic acc, cmd_have_r, drn_word, drn_end, rd_end, wr_rdy_r, cfg_ok_r;
  logic [5:0] rd_idx_r, rx_idx_r, buf_waddr;
  logic [6:0] drn_r;
  logic [7:0] pg_id_r, rd_id, nxt_wr_id, rd_seq_r, wr_seq_r;
  logic [8:0] wr_total;
  logic [15:0] buf_q, rd_word;
  logic [7:0] rd_cnt_r, wr_cnt_r, cmd_cnt_r, rd_start_r, wr_start_r;
  logic [7:0] rd_cnt_s, wr_cnt_s, cmd_cnt_s, rd_start_s, wr_start_s;

  //////////////////////////////////////////////////////////////////////////////
  // decode and page selection
  assign kind = btp_kind(pg_id_r);
  // a word is accepted only while running and while this end is listening
  assign acc = link.run && link.wr_valid && wr_rdy_r && (st_r == S_RECV || (st_r == S_IDLE && !link.rd_req));
  assign buf_waddr = (st_r == S_IDLE) ? 6'h00 : rx_idx_r;
  assign drn_word = (st_r == S_DRAIN) && (drn_r >= 7'h02);
  assign drn_end = (st_r == S_DRAIN) && (drn_r == DRAIN_END);
  assign rd_end = (st_r == S_READ) && (rd_idx_r == LAST_IDX);
  assign rd_id = 8'(rd_start_r + rd_seq_r);
  // command pages drop out of the rotation once the list is held
  assign wr_total = {1'b0, wr_cnt_r} + (cmd_have_r ? 9'h000 : {1'b0, cmd_cnt_r});

  // write page the controller is asked for next
  always_comb
  begin
    nxt_wr_id = wr_start_r;
    if (!cfg_ok_r) nxt_wr_id = ID_CFG;
    else if (wr_seq_r < wr_cnt_r) nxt_wr_id = 8'(wr_start_r + wr_seq_r);
    else if ({1'b0, wr_seq_r} < wr_total) nxt_wr_id = 8'(ID_CMD_MIN + wr_seq_r - wr_cnt_r);
  end

  // word presented on the read stream
  always_comb
  begin
    rd_word = usr_rd_data;
    if (rd_idx_r == 6'h00) rd_word = cfg_ok_r ? {8'h00, rd_id} : 16'h0000;
    else if (rd_idx_r == 6'h01) rd_word = {8'h00, nxt_wr_id};
  end

  //////////////////////////////////////////////////////////////////////////////
  // exchange sequencer; a read burst is cut short once the controller stops
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      // unconfigured or not, every read request is served
      S_IDLE:
        if (link.run && link.rd_req) st_nxt = S_READ;
        else if (acc && !link.wr_last) st_nxt = S_RECV;
      S_READ: if (!link.run || rd_end) st_nxt = S_IDLE;
      S_RECV:
        if (!link.run) st_nxt = S_IDLE;
        else if (acc && link.wr_last) st_nxt = (rx_idx_r == LAST_IDX) ? S_FULL : S_IDLE;
      S_FULL:
        if (!link.run) st_nxt = S_IDLE;
        else if (link.wr_done) st_nxt = (kind == KIND_NONE) ? S_IDLE : S_DRAIN;
      S_DRAIN: if (drn_end) st_nxt = S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) st_r <= S_IDLE;
    else st_r <= st_nxt;

  // word counters of the three streams
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_idx_r <= 6'h00;
      rx_idx_r <= 6'h00;
      drn_r <= 7'h00;
    end
    else
    begin
      rd_idx_r <= (st_r == S_READ) ? 6'(rd_idx_r + 6'h01) : 6'h00;
      if (st_r == S_IDLE) rx_idx_r <= 6'h01;
      else if (acc) rx_idx_r <= 6'(rx_idx_r + 6'h01);
      drn_r <= (st_r == S_DRAIN) ? 7'(drn_r + 7'h01) : 7'h01;
    end
  end

  // page identifier arrives in word 0
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) pg_id_r <= 8'h00;
    else if (acc && st_r == S_IDLE) pg_id_r <= link.wr_data[7:0];

  // the page only counts once all 64 words are in, so it is parked first
  btp_page_buf u_page (
    .hclk(hclk), .we(acc), .waddr(buf_waddr),
    .wdata(link.wr_data), .raddr(drn_r[5:0]), .rdata(buf_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // link outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      link.rd_valid <= 1'b0;
      link.rd_last <= 1'b0;
      link.rd_data <= 16'h0000;
      wr_rdy_r <= 1'b0;
      usr_rd_page <= 8'h00;
    end
    else
    begin
      link.rd_valid <= (st_r == S_READ);
      link.rd_last <= rd_end;
      link.rd_data <= rd_word;
      wr_rdy_r <= link.run && (st_nxt == S_IDLE || st_nxt == S_RECV);
      usr_rd_page <= rd_id;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // payload hand-off; configuration words are caught in shadows instead
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      usr_wr_valid <= 1'b0;
      usr_wr_kind <= KIND_NONE;
      usr_wr_page <= 8'h00;
      usr_wr_word <= 6'h00;
      usr_wr_data <= 16'h0000;
    end
    else
    begin
      usr_wr_valid <= drn_word && (kind != KIND_CFG);
      usr_wr_kind <= kind;
      usr_wr_page <= pg_id_r;
      usr_wr_word <= 6'(drn_r - 7'h01);
      usr_wr_data <= buf_q;
    end
  end

  // shadows keep a half-read page from disturbing the live settings;
  // no reset: a whole configuration page rewrites all of them before adoption
  always_ff @(posedge hclk)
  begin
    if (drn_word && kind == KIND_CFG)
    begin
      case (6'(drn_r - 7'h01))
        CFG_RD_CNT: rd_cnt_s <= buf_q[7:0];
        CFG_WR_CNT: wr_cnt_s <= buf_q[7:0];
        CFG_CMD_CNT: cmd_cnt_s <= buf_q[7:0];
        CFG_RD_START: rd_start_s <= buf_q[7:0];
        CFG_WR_START: wr_start_s <= buf_q[7:0];
        default: ;
      endcase
    end
  end

  // adopt a configuration page whenever one completes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_ok_r <= 1'b0;
      cfg_pulse <= 1'b0;
      rd_cnt_r <= 8'h00;
      wr_cnt_r <= 8'h00;
      cmd_cnt_r <= 8'h00;
      rd_start_r <= 8'h00;
      wr_start_r <= 8'h00;
    end
    else
    begin
      cfg_pulse <= drn_end && kind == KIND_CFG;
      if (drn_end && kind == KIND_CFG)
      begin
        cfg_ok_r <= 1'b1;
        rd_cnt_r <= rd_cnt_s;
        wr_cnt_r <= wr_cnt_s;
        cmd_cnt_r <= cmd_cnt_s;
        rd_start_r <= rd_start_s;
        wr_start_r <= wr_start_s;
      end
    end
  end

  // page rotation; a new configuration restarts it from the first data page
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_seq_r <= 8'h00;
      wr_seq_r <= 8'h00;
      cmd_have_r <= 1'b0;
    end
    else
    begin
      if (drn_end && kind == KIND_CFG) rd_seq_r <= 8'h00;
      else if (rd_end && cfg_ok_r) rd_seq_r <= (9'(rd_seq_r) + 9'h001 >= 9'(rd_cnt_r)) ? 8'h00 : 8'(rd_seq_r + 8'h01);
      if (drn_end && kind == KIND_CFG) wr_seq_r <= 8'h00;
      else if (drn_end && (kind == KIND_DATA || kind == KIND_CMD))
        wr_seq_r <= (9'(wr_seq_r) + 9'h001 >= wr_total) ? 8'h00 : 8'(wr_seq_r + 8'h01);
      // the last configured command page completes the list
      if (drn_end && kind == KIND_CMD && cmd_cnt_r != 8'h00 && pg_id_r == 8'(ID_CMD_MIN + cmd_cnt_r - 8'h01))
        cmd_have_r <= 1'b1;
    end
  end

  // activity flag follows the controller's run state once a configuration is adopted
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) comm_active <= 1'b0;
    else comm_active <= cfg_ok_r && link.run;
  // command execution needs the whole list as well
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) cmd_exec <= 1'b0;
    else cmd_exec <= cfg_ok_r && cmd_have_r && link.run;

  // flops read back inside the block
  assign link.wr_ready = wr_rdy_r;
  assign usr_rd_word = rd_idx_r;
  assign cfg_ok = cfg_ok_r;

endmodule : btp_dev_end
`default_nettype wire

// ===== src/btp_pkg.sv
// btp_pkg: constants and types shared by both ends of the paged block-transfer link
// assumes: 16-bit link words, 64-word pages, one clock (hclk) for both ends
package btp_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // page geometry
  localparam int unsigned WORD_W = 16;
  localparam int unsigned PAGE_WORDS = 64;
  localparam logic [5:0] LAST_IDX = 6'h3f;
  localparam logic [6:0] DRAIN_END = 7'h40;

  //////////////////////////////////////////////////////////////////////////////
  // page identifier ranges carried in word 0 of a write page
  localparam logic [7:0] ID_DATA_MAX = 8'h4f;
  localparam logic [7:0] ID_CMD_MIN = 8'h50;
  localparam logic [7:0] ID_CMD_MAX = 8'h63;
  localparam logic [7:0] ID_EVT_MIN = 8'h64;
  localparam logic [7:0] ID_EVT_MAX = 8'h78;
  localparam logic [7:0] ID_CFG = 8'hff;

  //////////////////////////////////////////////////////////////////////////////
  // word positions inside the configuration page
  localparam logic [5:0] CFG_RD_CNT = 6'h15;
  localparam logic [5:0] CFG_WR_CNT = 6'h16;
  localparam logic [5:0] CFG_CMD_CNT = 6'h17;
  localparam logic [5:0] CFG_RD_START = 6'h1c;
  localparam logic [5:0] CFG_WR_START = 6'h1d;

  //////////////////////////////////////////////////////////////////////////////
  // controller register map (byte offsets on the AHB-Lite port)
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STAT = 12'h004;
  localparam logic [11:0] REG_EVT = 12'h008;
  localparam logic [3:0] RDBUF_PAGE = 4'h1;
  localparam logic [3:0] WRBUF_PAGE = 4'h2;
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_CFG = 1;
  localparam int unsigned CTRL_EVT = 2;
  localparam logic [2:0] CTRL_RST = 3'h2;
  localparam logic [7:0] EVT_RST = 8'h64;

  //////////////////////////////////////////////////////////////////////////////
  // page kinds
  typedef enum logic [2:0] {KIND_DATA, KIND_CMD, KIND_EVT, KIND_CFG, KIND_NONE} btp_kind_t;

  // map a page identifier onto what the payload means
  function automatic btp_kind_t btp_kind(input logic [7:0] id);
    btp_kind_t k;
    k = KIND_NONE;
    if (id <= ID_DATA_MAX) k = KIND_DATA;
    else if (id >= ID_CMD_MIN && id <= ID_CMD_MAX) k = KIND_CMD;
    else if (id >= ID_EVT_MIN && id <= ID_EVT_MAX) k = KIND_EVT;
    else if (id == ID_CFG) k = KIND_CFG;
    return k;
  endfunction : btp_kind

endpackage : btp_pkg

// ===== src/btp_link_if.sv
// btp_link_if: word-wide exchange between controller and module
// assumes: both ends on hclk; the bench joins them and supplies the clock
`timescale 1ns/1ps
`default_nettype none
interface btp_link_if;
  logic run;
  logic rd_req;
  logic rd_valid;
  logic [15:0] rd_data;
  logic rd_last;
  logic wr_valid;
  logic [15:0] wr_data;
  logic wr_last;
  logic wr_ready;
  logic wr_done;

  // module end
  modport dev (input run, rd_req, wr_valid, wr_data, wr_last, wr_done,
               output rd_valid, rd_data, rd_last, wr_ready);
  // controller end
  modport host (output run, rd_req, wr_valid, wr_data, wr_last, wr_done,
                input rd_valid, rd_data, rd_last, wr_ready);
endinterface : btp_link_if
`default_nettype wire

// ===== src/btp_page_buf.sv
// btp_page_buf: one 64-word page held until the whole page has arrived
// assumes: single clock, registered read with one cycle of latency
`timescale 1ns/1ps
`default_nettype none
module btp_page_buf
  import btp_pkg::*;
(
  // clock
  input wire logic hclk,
  // write side
  input wire logic we,
  input wire logic [5:0] waddr,
  input wire logic [15:0] wdata,
  // read side
  input wire logic [5:0] raddr,
  output logic [15:0] rdata
);

  logic [15:0] mem [0:PAGE_WORDS-1];

  // storage needs no reset: nothing is read before a full page was written
  always_ff @(posedge hclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge hclk)
  begin
    rdata <= mem[raddr];
  end

endmodule : btp_page_buf
`default_nettype wire

// ===== src/btp_host_end.sv
// btp_host_end: controller end, runs read/write page cycles ordered over AHB-Lite
// assumes: single AHB-Lite master and this as the only slave; module end on hclk
`timescale 1ns/1ps
`default_nettype none
module btp_host_end
  import btp_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // link to the module
  btp_link_if.host link
);

  typedef enum logic [2:0] {H_IDLE, H_REQ, H_READ, H_PREP, H_WRITE, H_DONE} btp_host_st_t;

  btp_host_st_t hs_r;
  logic [15:0] rd_mem [0:PAGE_WORDS-1];
  logic [15:0] wr_mem [0:PAGE_WORDS-1];
  logic [5:0] idx_r;
  logic [7:0] wr_id_r, rd_id_r, evt_id_r, pick;
  logic run_r, cfg_en_r, evt_en_r;
  logic a_wr_r, a_rd_r;
  logic [11:0] a_addr_r;
  logic [31:0] rmux;
  logic hrdy_r, hresp_r;
  logic [31:0] hrdata_r;
  logic rd_req_r, wr_valid_r, wr_last_r, wr_done_r;
  logic [15:0] wr_data_r;
  logic wr_ctrl;

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes complete at once, reads take one wait state

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_wr_r <= 1'b0;
      a_rd_r <= 1'b0;
      a_addr_r <= 12'h000;
      hrdy_r <= 1'b1;
      hresp_r <= 1'b0;
      hrdata_r <= 32'h0000_0000;
    end
    else
    begin
      a_wr_r <= hsel && htrans[1] && hready && hwrite;
      a_rd_r <= hsel && htrans[1] && hready && !hwrite;
      if (hsel && htrans[1] && hready) a_addr_r <= haddr[11:0];
      hrdy_r <= !(hsel && htrans[1] && hready && !hwrite);
      if (a_rd_r) hrdata_r <= rmux;
    end
  end

  // read decode; unmapped words read as zero
  always_comb
  begin
    rmux = 32'h0000_0000;
    if (a_addr_r == REG_CTRL) rmux = {29'h0000_0000, evt_en_r, cfg_en_r, run_r};
    else if (a_addr_r == REG_STAT) rmux = {8'h00, wr_id_r, rd_id_r, 7'h00, hs_r != H_IDLE};
    else if (a_addr_r == REG_EVT) rmux = {24'h00_0000, evt_id_r};
    else if (a_addr_r[11:8] == RDBUF_PAGE) rmux = {16'h0000, rd_mem[a_addr_r[7:2]]};
    else if (a_addr_r[11:8] == WRBUF_PAGE) rmux = {16'h0000, wr_mem[a_addr_r[7:2]]};
  end

  assign wr_ctrl = a_wr_r && a_addr_r == REG_CTRL;

  // control bits; a software set in the clearing cycle wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_r <= CTRL_RST[CTRL_RUN];
      cfg_en_r <= CTRL_RST[CTRL_CFG];
      evt_en_r <= CTRL_RST[CTRL_EVT];
      evt_id_r <= EVT_RST;
    end
    else
    begin
      if (wr_ctrl) run_r <= hwdata[CTRL_RUN];
      if (wr_ctrl && hwdata[CTRL_CFG]) cfg_en_r <= 1'b1;
      else if (hs_r == H_PREP) cfg_en_r <= 1'b0;
      if (wr_ctrl && hwdata[CTRL_EVT]) evt_en_r <= 1'b1;
      else if (hs_r == H_PREP && !cfg_en_r) evt_en_r <= 1'b0;
      if (a_wr_r && a_addr_r == REG_EVT) evt_id_r <= hwdata[7:0];
    end
  end

  // write page source filled by software
  always_ff @(posedge hclk)
  begin
    if (a_wr_r && a_addr_r[11:8] == WRBUF_PAGE) wr_mem[a_addr_r[7:2]] <= hwdata[15:0];
  end

  // read page image, kept for software to file away
  always_ff @(posedge hclk)
  begin
    if (link.rd_valid) rd_mem[idx_r] <= link.rd_data;
  end

  //////////////////////////////////////////////////////////////////////////////
  // page cycle: read a page, then write the configuration page, the event page or the page the module asked for

  // configuration first, then events, else the module's own choice
  always_comb
  begin
    pick = wr_id_r;
    if (cfg_en_r) pick = ID_CFG;
    else if (evt_en_r) pick = evt_id_r;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hs_r <= H_IDLE;
      idx_r <= 6'h00;
      rd_id_r <= 8'h00;
      wr_id_r <= 8'h00;
      rd_req_r <= 1'b0;
      wr_valid_r <= 1'b0;
      wr_last_r <= 1'b0;
      wr_data_r <= 16'h0000;
      wr_done_r <= 1'b0;
    end
    else if (!run_r)
    begin
      // stopping drops the link at once; the module halts too
      hs_r <= H_IDLE;
      rd_req_r <= 1'b0;
      wr_valid_r <= 1'b0;
      wr_last_r <= 1'b0;
      wr_done_r <= 1'b0;
    end
    else
    begin
      wr_done_r <= 1'b0;
      case (hs_r)
        H_IDLE:
        begin
          rd_req_r <= 1'b1;
          idx_r <= 6'h00;
          hs_r <= H_REQ;
        end
        // request stays up until the module starts answering
        H_REQ, H_READ:
        begin
          if (link.rd_valid)
          begin
            rd_req_r <= 1'b0;
            idx_r <= 6'(idx_r + 6'h01);
            if (idx_r == 6'h00) rd_id_r <= link.rd_data[7:0];
            if (idx_r == 6'h01) wr_id_r <= link.rd_data[7:0];
            hs_r <= link.rd_last ? H_PREP : H_READ;
          end
        end
        H_PREP:
        begin
          wr_id_r <= pick;
          wr_data_r <= {8'h00, pick};
          wr_valid_r <= 1'b1;
          idx_r <= 6'h00;
          hs_r <= H_WRITE;
        end
        // always the full 64 words, used or not
        H_WRITE:
        begin
          if (link.wr_ready)
          begin
            if (idx_r == LAST_IDX)
            begin
              wr_valid_r <= 1'b0;
              wr_last_r <= 1'b0;
              hs_r <= H_DONE;
            end
            else
            begin
              idx_r <= 6'(idx_r + 6'h01);
              wr_data_r <= wr_mem[6'(idx_r + 6'h01)];
              wr_last_r <= (6'(idx_r + 6'h01) == LAST_IDX);
            end
          end
        end
        H_DONE:
        begin
          wr_done_r <= 1'b1;
          hs_r <= H_IDLE;
        end
        default: hs_r <= H_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output wiring

  assign hreadyout = hrdy_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;
  assign link.run = run_r;
  assign link.rd_req = rd_req_r;
  assign link.wr_valid = wr_valid_r;
  assign link.wr_data = wr_data_r;
  assign link.wr_last = wr_last_r;
  assign link.wr_done = wr_done_r;

endmodule : btp_host_end
`default_nettype wire

// ===== test/btp_link_properties.sv
// btp_link_chk: timing relations on the link between the two ends
// assumes: plain btp_link_if signals, one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module btp_link_chk
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link
  input wire logic run,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic rd_last,
  input wire logic wr_valid,
  input wire logic [15:0] wr_data,
  input wire logic wr_last,
  input wire logic wr_ready,
  input wire logic wr_done
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [5:0] rd_cnt_r;
  logic [6:0] wr_cnt_r;
  logic [7:0] wr_id_r;
  logic cfg_seen_r;
  logic take;
  assign take = wr_valid && wr_ready && run;
  //////////////////////////////////////////////////////////////////////////////
  // read word index; wraps only if a burst overruns 64 words
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) rd_cnt_r <= 6'h00;
    else rd_cnt_r <= rd_valid ? rd_cnt_r + 6'h01 : 6'h00;
  // write word count, cleared at commit or halt
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) wr_cnt_r <= 7'h00;
    else if (wr_done || !run) wr_cnt_r <= 7'h00;
    else if (take) wr_cnt_r <= wr_cnt_r + 7'h01;
  // page id of the write page in flight
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) wr_id_r <= 8'h00;
    else if (take && wr_cnt_r == 7'h00) wr_id_r <= wr_data[7:0];
  // a whole configuration page has been committed
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) cfg_seen_r <= 1'b0;
    else if (wr_done && wr_id_r == 8'hff && wr_cnt_r == 7'h40) cfg_seen_r <= 1'b1;
  //////////////////////////////////////////////////////////////////////////////
  sequence s_wr_end;
    take && wr_last ##1 !wr_valid && run;
  endsequence
  property p_rd_start; $rose(rd_valid) |-> $past(rd_req); endproperty
  property p_rd_len; rd_valid && rd_cnt_r == 6'h00 |-> $rose(rd_valid); endproperty
  property p_rd_last; rd_last == (rd_valid && rd_cnt_r == 6'h3f); endproperty
  property p_halt; !run && !rd_valid |=> !rd_valid; endproperty
  property p_w0; rd_valid && rd_cnt_r == 6'h00 && !cfg_seen_r |-> rd_data == 16'h0000; endproperty
  property p_w1; rd_valid && rd_cnt_r == 6'h01 && !cfg_seen_r |-> rd_data == 16'h00ff; endproperty
  property p_wr_last; take && wr_last |-> wr_cnt_r == 7'h3f; endproperty
  property p_wr_hold; wr_valid && !wr_ready && run |=> !run || (wr_valid && $stable(wr_data)); endproperty
  property p_wr_done; s_wr_end |=> wr_done || !run; endproperty
  property p_done_cause; wr_done |-> $past(wr_last, 2); endproperty
  a_rd_start: assert property (p_rd_start) else $error("read burst without request");
  a_rd_len: assert property (p_rd_len) else $error("read burst longer than a page");
  a_rd_last: assert property (p_rd_last) else $error("last flag not on word 63");
  a_halt: assert property (p_halt) else $error("read started while halted");
  a_w0: assert property (p_w0) else $error("word 0 not zero before setup");
  a_w1: assert property (p_w1) else $error("word 1 not 255 before setup");
  a_wr_last: assert property (p_wr_last) else $error("write page not 64 words");
  a_wr_hold: assert property (p_wr_hold) else $error("write word changed while waiting");
  a_wr_done: assert property (p_wr_done) else $error("no commit after page");
  a_done_cause: assert property (p_done_cause) else $error("commit without page end");
endmodule : btp_link_chk
`default_nettype wire

// ===== test/tb_top.sv
// tb_top: both link ends joined, controller driven over AHB-Lite
// assumes: single slave, hready looped from hreadyout, 200 MHz hclk
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top
  import btp_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, usr_wr_valid, cfg_ok, cfg_pulse, comm_active;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] usr_rd_word;
  logic [7:0] usr_wr_page;
  logic [15:0] usr_rd_data, usr_wr_data, last_d;
  btp_kind_t usr_wr_kind;
  int err_count, checks, wr_n, bad_n, cfg_n, cyc;
  btp_link_if i_btp_link_if();
  btp_host_end i_btp_host_end (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(),
    .hrdata(hrdata), .link(i_btp_link_if));
  btp_dev_end i_btp_dev_end (.hclk(hclk), .hresetn(hresetn), .link(i_btp_link_if), .usr_rd_page(),
    .usr_rd_word(usr_rd_word), .usr_rd_data(usr_rd_data), .usr_wr_valid(usr_wr_valid),
    .usr_wr_kind(usr_wr_kind), .usr_wr_page(usr_wr_page), .usr_wr_word(), .usr_wr_data(usr_wr_data),
    .cfg_ok(cfg_ok), .cfg_pulse(cfg_pulse), .comm_active(comm_active), .cmd_exec());
  btp_link_chk i_btp_link_chk (.hclk(hclk), .hresetn(hresetn), .run(i_btp_link_if.run),
    .rd_req(i_btp_link_if.rd_req), .rd_valid(i_btp_link_if.rd_valid), .rd_data(i_btp_link_if.rd_data),
    .rd_last(i_btp_link_if.rd_last), .wr_valid(i_btp_link_if.wr_valid), .wr_data(i_btp_link_if.wr_data),
    .wr_last(i_btp_link_if.wr_last), .wr_ready(i_btp_link_if.wr_ready), .wr_done(i_btp_link_if.wr_done));
  //////////////////////////////////////////////////////////////////////////////
  // payload source answers in the same cycle, tagged with the word index
  assign usr_rd_data = {8'h5a, 2'h0, usr_rd_word};
  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;
  // sink monitor; pulses stand one cycle so they are sampled at every edge
  always @(posedge hclk)
  begin
    if (usr_wr_valid === 1'b1 && usr_wr_kind === KIND_DATA && usr_wr_page === 8'h05) wr_n++;
    if (usr_wr_valid === 1'b1 && usr_wr_page === 8'h79) bad_n++;
    if (usr_wr_valid === 1'b1) last_d = usr_wr_data;
    if (cfg_pulse === 1'b1) cfg_n++;
  end
  // watchdog, well beyond the roughly 1200 cycles the run needs
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_count++;
      end_sim();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  // one single AHB-Lite transfer; the slave decides when it answers
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb
  // page source: one read page, one write page starting at 5, no commands
  function automatic logic [31:0] pw(input int i);
    case (i)
      21, 22: return 32'h0000_0001;
      23: return 32'h0000_0000;
      28: return 32'h0000_0003;
      29: return 32'h0000_0005;
      default: return 32'(i);
    endcase
  endfunction : pw
  task automatic wait_commit();
    while (i_btp_link_if.wr_done !== 1'b1) @(posedge hclk);
    repeat (70) @(posedge hclk);
  endtask : wait_commit
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, 32'h0000_0000, 0, q); `CHK("ctrl reset", 32'h0000_0002, q)
    for (int i = 1; i < 64; i++) ahb(1, 32'h0000_0200 + 32'(4 * i), pw(i), q);
    ahb(1, 32'h0000_0000, 32'h0000_0003, q);
    while (i_btp_link_if.rd_last !== 1'b1) @(posedge hclk);
    ahb(0, 32'h0000_0100, 0, q); `CHK("rd w0 idle", 32'h0000_0000, q)
    ahb(0, 32'h0000_0104, 0, q); `CHK("rd w1 idle", 32'h0000_00ff, q)
    while (cfg_ok !== 1'b1) @(posedge hclk);
    ahb(0, 32'h0000_0004, 0, q); `CHK("wr id", 8'hff, q[23:16])
    `CHK("cfg count", 1, cfg_n)
    while (i_btp_link_if.rd_last !== 1'b1) @(posedge hclk);
    ahb(0, 32'h0000_0100, 0, q); `CHK("rd page", 32'h0000_0003, q)
    ahb(0, 32'h0000_0104, 0, q); `CHK("wr request", 32'h0000_0005, q)
    ahb(0, 32'h0000_0108, 0, q); `CHK("rd payload", 32'h0000_5a02, q)
    wait_commit();
    `CHK("data words", 63, wr_n)
    `CHK("last word", 16'h003f, last_d)
    ahb(1, 32'h0000_0000, 32'h0000_0000, q);
    repeat (140) @(posedge hclk);
    `CHK("halted", 1'b0, comm_active)
    `CHK("no read", 1'b0, i_btp_link_if.rd_valid)
    ahb(1, 32'h0000_0000, 32'h0000_0003, q);
    while (cfg_n != 2) @(posedge hclk);
    repeat (2) @(posedge hclk);
    `CHK("resumed", 1'b1, comm_active)
    ahb(1, 32'h0000_0008, 32'h0000_0079, q);
    ahb(1, 32'h0000_0000, 32'h0000_0005, q);
    do ahb(0, 32'h0000_0004, 0, q); while (q[23:16] !== 8'h79);
    wait_commit();
    `CHK("unknown page", 0, bad_n)
    ahb(0, 32'h0000_0000, 0, q); `CHK("evt cleared", 32'h0000_0001, q)
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
